// ==== rtl/isp_pkg.sv ====
// Purpose: Constants for the input synchronization parameter object.
// Assumes: Register port addressed by subindex, 25 MHz system clock.
// Notes:   Every offset, reset value and timing count is named here once.
package isp_pkg;
  // Subindex of each entry.
  localparam logic [7:0]  SUB_COUNT      = 8'h00;
  localparam logic [7:0]  SUB_MODE       = 8'h01;
  localparam logic [7:0]  SUB_CYCLE      = 8'h02;
  localparam logic [7:0]  SUB_SHIFT      = 8'h03;
  localparam logic [7:0]  SUB_SUPPORTED  = 8'h04;
  localparam logic [7:0]  SUB_MIN_CYCLE  = 8'h05;
  localparam logic [7:0]  SUB_CALC       = 8'h06;
  localparam logic [7:0]  SUB_MIN_DELAY  = 8'h07;
  localparam logic [7:0]  SUB_COMMAND    = 8'h08;
  localparam logic [7:0]  SUB_MAX_DELAY  = 8'h09;
  localparam logic [7:0]  SUB_MISSED     = 8'h0b;
  localparam logic [7:0]  SUB_OVERRUN    = 8'h0c;
  localparam logic [7:0]  SUB_SHORT      = 8'h0d;
  localparam logic [7:0]  SUB_FAULT      = 8'h20;
  // Reset and fixed values.
  localparam logic [7:0]  COUNT_RST      = 8'h20;
  localparam logic [15:0] MODE_RST       = 16'h0022;
  localparam logic [31:0] CYCLE_RST      = 32'h000f4240;
  localparam logic [15:0] SUPPORTED_RST  = 16'h0002;
  localparam logic [31:0] MIN_CYCLE_RST  = 32'h000186a0;
  localparam logic [31:0] MIN_DELAY_RST  = 32'h00000000;
  localparam logic [15:0] CMD_RST        = 16'h0000;
  // Sync mode encodings.
  localparam logic [15:0] MODE_FREE_RUN  = 16'h0000;
  localparam logic [15:0] MODE_SM3       = 16'h0001;
  localparam logic [15:0] MODE_SYNC0     = 16'h0002;
  localparam logic [15:0] MODE_SYNC1     = 16'h0003;
  localparam logic [15:0] MODE_SM2       = 16'h0022;
  // Measurement command encodings and the counter saturation value.
  localparam logic [15:0] CMD_STOP       = 16'h0000;
  localparam logic [15:0] CMD_START      = 16'h0001;
  localparam logic [15:0] CNT_MAX        = 16'hffff;
  // Clock rate and the nanoseconds that one clock period adds.
  localparam int unsigned CLK_FREQ_HZ    = 25_000_000;
  localparam int unsigned NS_PER_SEC     = 1_000_000_000;
  localparam logic [31:0] NS_PER_CLK     = 32'(NS_PER_SEC / CLK_FREQ_HZ);
  // Input pins, in the order of the synchroniser vector.
  localparam int unsigned PIN_SYNC0      = 0;
  localparam int unsigned PIN_SYNC1      = 1;
  localparam int unsigned PIN_SM         = 2;
  localparam int unsigned PIN_SAMPLE     = 3;
  localparam int unsigned PIN_READY      = 4;
  localparam int unsigned PIN_OP         = 5;
  localparam int unsigned PIN_N          = 6;
endpackage : isp_pkg

// ==== rtl/isp_input_sync.sv ====
// Purpose: Input synchronization parameter object of a fieldbus slave.
// Assumes: Event pins are asynchronous levels; an event is a rising edge.
// Notes:   Reads answer one cycle after the strobe; times count in ns.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RL1: Writable sync mode, reset 0x0022, picks the input sampling event.
// RL2: In DC mode report ns from SYNC0 event to input sampling.
// RL3: In DC mode report ns from sampling until inputs are ready.
// RL4: In DC mode report ns from SYNC1 event to sampling as maximum delay.
// RL5: Supported modes word reads 0x0002: free run, SM event, DC bits.
// RL6: Bits 4 to 5 encode the input shift source of the supported word.
// RL7: Bit 14 of supported word flags dynamic times measured by command; the word here reads 0x0002, bit 14 clear.
// RL8: Subindex zero reads 0x20, the highest subindex.
// RL9: Command 1 starts measuring with maxima kept; command 0 stops it.
// RL10: Cycle time in ns; in free run it paces the local timer.
// RL11: Operational DC mode counts missed sync manager events, 16 bits.
// RL12: Sync fault flag shows the last DC cycle had no sampling, or inputs not ready, by the next SYNC0.
// RL13: Overrun and short shift counters reset to zero and saturate.
module isp_input_sync (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_subidx,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        sync0_pin,
  input  wire logic        sync1_pin,
  input  wire logic        sm_event_pin,
  input  wire logic        sample_done_pin,
  input  wire logic        inputs_ready_pin,
  input  wire logic        op_state_pin,
  output logic      [31:0] reg_rdata,
  output logic             reg_rd_valid,
  output logic             reg_err,
  output logic             sample_req,
  output logic             sync_fault
);

  typedef struct packed {
    logic [15:0] mode;
    logic [31:0] cycle;
    logic [31:0] shift;
    logic [31:0] calc;
    logic [31:0] max_dly;
    logic [15:0] cmd;
    logic [15:0] missed;
    logic [15:0] overrun;
    logic [15:0] short_cnt;
    logic        fault;
    logic [31:0] now;
    logic [31:0] t_s0;
    logic [31:0] t_s1;
    logic [31:0] t_smp;
    logic [31:0] run_acc;
    logic        sm_seen;
    logic        s0_seen;
    logic        smp_seen;
    logic        pend;
    logic [isp_pkg::PIN_N-1:0] meta;
    logic [isp_pkg::PIN_N-1:0] sync2;
    logic [isp_pkg::PIN_N-1:0] prev;
    logic        req;
    logic [31:0] rdata;
    logic        rvalid;
    logic        rerr;
  } isp_state_t;

  isp_state_t st_ff;
  isp_state_t nxt_st;

  logic [isp_pkg::PIN_N-1:0] pins;
  logic [isp_pkg::PIN_N-1:0] edge_w;
  logic        dc_mode;
  logic        measuring;
  logic        run_tick;
  logic        cyc_evt;
  logic        mode_ok;
  logic [31:0] d_shift;
  logic [31:0] d_calc;
  logic [31:0] d_maxd;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign pins = {op_state_pin, inputs_ready_pin, sample_done_pin,
                 sm_event_pin, sync1_pin, sync0_pin};

  // Edges come from the second and third stages only; the first is metastable.
  assign edge_w    = st_ff.sync2 & ~st_ff.prev;
  assign dc_mode   = (st_ff.mode == isp_pkg::MODE_SYNC0) ||
                     (st_ff.mode == isp_pkg::MODE_SYNC1);
  assign measuring = (st_ff.cmd == isp_pkg::CMD_START); // RL9
  // One carry bit keeps a cycle near the 32-bit limit from never ticking.
  assign run_tick  = ({1'b0, st_ff.run_acc} + {1'b0, isp_pkg::NS_PER_CLK}) >=
                     {1'b0, st_ff.cycle}; // RL10
  assign d_shift   = st_ff.now - st_ff.t_s0;
  assign d_calc    = st_ff.now - st_ff.t_smp;
  assign d_maxd    = st_ff.now - st_ff.t_s1;
  assign mode_ok   = (reg_wdata[31:16] == 16'h0000) &&
                     (reg_wdata[15:0] == isp_pkg::MODE_FREE_RUN ||
                      reg_wdata[15:0] == isp_pkg::MODE_SM3 ||
                      reg_wdata[15:0] == isp_pkg::MODE_SYNC0 ||
                      reg_wdata[15:0] == isp_pkg::MODE_SYNC1 ||
                      reg_wdata[15:0] == isp_pkg::MODE_SM2);

  // The selected mode decides which event starts a sampling cycle.
  always_comb begin
    case (st_ff.mode)
      isp_pkg::MODE_FREE_RUN: cyc_evt = run_tick; // RL1 RL10
      isp_pkg::MODE_SM3,
      isp_pkg::MODE_SM2:      cyc_evt = edge_w[isp_pkg::PIN_SM]; // RL1
      isp_pkg::MODE_SYNC0:    cyc_evt = edge_w[isp_pkg::PIN_SYNC0]; // RL1
      isp_pkg::MODE_SYNC1:    cyc_evt = edge_w[isp_pkg::PIN_SYNC1]; // RL1
      default:                cyc_evt = 1'b0;
    endcase
  end

  // Read multiplexer; narrow entries sit in the low bits.
  always_comb begin
    rd_hit = 1'b1;
    case (reg_subidx)
      isp_pkg::SUB_COUNT:     rd_val = {24'h000000, isp_pkg::COUNT_RST}; // RL8
      isp_pkg::SUB_MODE:      rd_val = {16'h0000, st_ff.mode};
      isp_pkg::SUB_CYCLE:     rd_val = st_ff.cycle;
      isp_pkg::SUB_SHIFT:     rd_val = st_ff.shift;
      isp_pkg::SUB_SUPPORTED:
        rd_val = {16'h0000, isp_pkg::SUPPORTED_RST}; // RL5 RL6 RL7
      isp_pkg::SUB_MIN_CYCLE: rd_val = isp_pkg::MIN_CYCLE_RST;
      isp_pkg::SUB_CALC:      rd_val = st_ff.calc;
      isp_pkg::SUB_MIN_DELAY: rd_val = isp_pkg::MIN_DELAY_RST;
      isp_pkg::SUB_COMMAND:   rd_val = {16'h0000, st_ff.cmd};
      isp_pkg::SUB_MAX_DELAY: rd_val = st_ff.max_dly;
      isp_pkg::SUB_MISSED:    rd_val = {16'h0000, st_ff.missed};
      isp_pkg::SUB_OVERRUN:   rd_val = {16'h0000, st_ff.overrun};
      isp_pkg::SUB_SHORT:     rd_val = {16'h0000, st_ff.short_cnt};
      isp_pkg::SUB_FAULT:     rd_val = {31'h00000000, st_ff.fault};
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Next-state logic for the whole object.
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.meta   = pins;
    nxt_st.sync2  = st_ff.meta;
    nxt_st.prev   = st_ff.sync2;
    nxt_st.now    = st_ff.now + isp_pkg::NS_PER_CLK;
    nxt_st.req    = cyc_evt;
    nxt_st.rvalid = reg_rd_en;
    nxt_st.rerr   = 1'b0;
    nxt_st.rdata  = reg_rd_en ? rd_val : 32'h00000000;
    if (reg_rd_en && !rd_hit) begin
      nxt_st.rerr = 1'b1;
    end
    // The free-running timer restarts when it reaches the cycle time.
    if (st_ff.mode != isp_pkg::MODE_FREE_RUN || run_tick) begin
      nxt_st.run_acc = 32'h00000000; // RL10
    end else begin
      nxt_st.run_acc = st_ff.run_acc + isp_pkg::NS_PER_CLK;
    end
    // Event timestamps and per-cycle bookkeeping.
    if (edge_w[isp_pkg::PIN_SYNC0]) begin
      nxt_st.t_s0     = st_ff.now;
      nxt_st.s0_seen  = 1'b1;
      nxt_st.sm_seen  = 1'b0;
      nxt_st.smp_seen = 1'b0;
      if (dc_mode && st_ff.s0_seen) begin
        nxt_st.fault = !st_ff.smp_seen || st_ff.pend; // RL12
      end
      if (dc_mode && st_ff.s0_seen && !st_ff.sm_seen &&
          st_ff.sync2[isp_pkg::PIN_OP] &&
          st_ff.missed != isp_pkg::CNT_MAX) begin
        nxt_st.missed = st_ff.missed + 16'h0001; // RL11
      end
    end
    if (!dc_mode) begin
      nxt_st.fault = 1'b0; // RL12
    end
    if (edge_w[isp_pkg::PIN_SM]) begin
      nxt_st.sm_seen = 1'b1;
    end
    if (edge_w[isp_pkg::PIN_SYNC1]) begin
      nxt_st.t_s1 = st_ff.now;
      // Sampling not yet done when SYNC1 arrives: the gap was too short.
      if (dc_mode && st_ff.s0_seen && !st_ff.smp_seen &&
          st_ff.short_cnt != isp_pkg::CNT_MAX) begin
        nxt_st.short_cnt = st_ff.short_cnt + 16'h0001; // RL13
      end
    end
    // A new cycle while the last one is still in flight is an overrun.
    if (cyc_evt && st_ff.pend && st_ff.sync2[isp_pkg::PIN_OP] &&
        st_ff.overrun != isp_pkg::CNT_MAX) begin
      nxt_st.overrun = st_ff.overrun + 16'h0001; // RL13
    end
    if (edge_w[isp_pkg::PIN_SAMPLE]) begin
      nxt_st.t_smp    = st_ff.now;
      nxt_st.smp_seen = 1'b1;
      nxt_st.pend     = 1'b1;
      if (dc_mode && (!measuring || d_shift > st_ff.shift)) begin
        nxt_st.shift = d_shift; // RL2 RL9
      end
      if (dc_mode && (!measuring || d_maxd > st_ff.max_dly)) begin
        nxt_st.max_dly = d_maxd; // RL4 RL9
      end
    end
    if (edge_w[isp_pkg::PIN_READY]) begin
      nxt_st.pend = 1'b0;
      if (dc_mode && (!measuring || d_calc > st_ff.calc)) begin
        nxt_st.calc = d_calc; // RL3 RL9
      end
    end
    // Register writes; read-only entries and bad values are refused.
    if (reg_wr_en) begin
      case (reg_subidx)
        isp_pkg::SUB_MODE: begin
          if (mode_ok) nxt_st.mode = reg_wdata[15:0]; // RL1
          else nxt_st.rerr = 1'b1; // RL1
        end
        isp_pkg::SUB_CYCLE: nxt_st.cycle = reg_wdata; // RL10
        isp_pkg::SUB_COMMAND: begin
          if (reg_wdata == {16'h0000, isp_pkg::CMD_START}) begin
            nxt_st.cmd = isp_pkg::CMD_START; // RL9
            if (!measuring) begin
              // A fresh measurement starts from zero maxima.
              nxt_st.shift   = 32'h00000000; // RL9
              nxt_st.calc    = 32'h00000000;
              nxt_st.max_dly = 32'h00000000;
            end
          end else if (reg_wdata == {16'h0000, isp_pkg::CMD_STOP}) begin
            nxt_st.cmd = isp_pkg::CMD_STOP; // RL9
          end else begin
            nxt_st.rerr = 1'b1;
          end
        end
        default: nxt_st.rerr = 1'b1;
      endcase
    end
  end

  // Single state register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff       <= '0; // RL13
      st_ff.mode  <= isp_pkg::MODE_RST; // RL1
      st_ff.cycle <= isp_pkg::CYCLE_RST; // RL10
      st_ff.cmd   <= isp_pkg::CMD_RST; // RL9
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata    = st_ff.rdata;
  assign reg_rd_valid = st_ff.rvalid;
  assign reg_err      = st_ff.rerr;
  assign sample_req   = st_ff.req;
  assign sync_fault   = st_ff.fault;

  // Checks of the documented behaviour.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_mode_reset;
    $rose(rst_n) |-> st_ff.mode == isp_pkg::MODE_RST
      && st_ff.missed == 16'h0000;
  endproperty
  a_mode_reset: assert property (p_mode_reset) // RL1
    else $error("bad reset state");

  property p_sync0_sample;
    edge_w[isp_pkg::PIN_SYNC0] && st_ff.mode == isp_pkg::MODE_SYNC0
      && !reg_wr_en |=> sample_req;
  endproperty
  a_sync0_sample: assert property (p_sync0_sample) // RL1
    else $error("no sample");

  property p_bad_mode;
    reg_wr_en && reg_subidx == isp_pkg::SUB_MODE && !mode_ok
      |=> $stable(st_ff.mode) && reg_err;
  endproperty
  a_bad_mode: assert property (p_bad_mode) // RL1
    else $error("bad mode taken");

  property p_shift;
    edge_w[isp_pkg::PIN_SAMPLE] && dc_mode && !reg_wr_en
      && d_shift > st_ff.shift |=> st_ff.shift == $past(d_shift);
  endproperty
  a_shift: assert property (p_shift) else $error("shift not kept"); // RL2

  property p_calc;
    edge_w[isp_pkg::PIN_READY] && dc_mode && !reg_wr_en
      && d_calc > st_ff.calc |=> st_ff.calc == $past(d_calc);
  endproperty
  a_calc: assert property (p_calc) else $error("calc not kept"); // RL3

  property p_maxd;
    edge_w[isp_pkg::PIN_SAMPLE] && dc_mode && !reg_wr_en
      && d_maxd > st_ff.max_dly |=> st_ff.max_dly == $past(d_maxd);
  endproperty
  a_maxd: assert property (p_maxd) else $error("delay not kept"); // RL4

  property p_supported;
    reg_rd_en && reg_subidx == isp_pkg::SUB_SUPPORTED
      |=> reg_rd_valid && reg_rdata == 32'h00000002 && !reg_err;
  endproperty
  a_supported: assert property (p_supported) // RL5
    else $error("bad modes word");

  property p_count;
    reg_rd_en && reg_subidx == isp_pkg::SUB_COUNT
      |=> reg_rdata == 32'h00000020;
  endproperty
  a_count: assert property (p_count) else $error("bad entry count"); // RL8

  property p_start;
    reg_wr_en && reg_subidx == isp_pkg::SUB_COMMAND && !measuring
      && reg_wdata == 32'h00000001 |=> measuring && st_ff.shift == 32'h0;
  endproperty
  a_start: assert property (p_start) else $error("start failed"); // RL9

  property p_missed;
    st_ff.missed != isp_pkg::CNT_MAX |=>
      st_ff.missed == $past(st_ff.missed)
      || st_ff.missed == $past(st_ff.missed) + 16'h0001;
  endproperty
  a_missed: assert property (p_missed) else $error("missed jumped"); // RL11

  property p_fault_dc;
    !dc_mode |=> !sync_fault;
  endproperty
  a_fault_dc: assert property (p_fault_dc) // RL12
    else $error("fault outside dc");

  // The counter only holds or steps by one, and never steps from the top.
  property p_saturate;
    st_ff.overrun == $past(st_ff.overrun)
      || ($past(st_ff.overrun) != isp_pkg::CNT_MAX
          && st_ff.overrun == $past(st_ff.overrun) + 16'h0001);
  endproperty
  a_saturate: assert property (p_saturate) // RL13
    else $error("overrun wrapped");

  c_fault:   cover property (dc_mode && $rose(sync_fault));
  c_missed:  cover property (st_ff.missed == 16'h0002);
  c_measure: cover property (measuring && edge_w[isp_pkg::PIN_READY]);

endmodule : isp_input_sync

`default_nettype wire

// ==== dv/isp_event_src.sv ====
// Purpose: Far-side event source for the input sync parameter bench.
// Assumes: One 40-clock cycle per call; pins change 1 ns after an edge.
// Notes:   Pulses last two clocks so the pin synchroniser sees each one.
`timescale 1ns/1ps
`default_nettype none

module isp_event_src (
  input  wire logic clk_sys,
  output var  logic sync0_pin,
  output var  logic sync1_pin,
  output var  logic sm_event_pin,
  output var  logic sample_done_pin,
  output var  logic inputs_ready_pin
);
  // All event lines idle low between pulses.
  initial begin
    sync0_pin        = 1'b0;
    sync1_pin        = 1'b0;
    sm_event_pin     = 1'b0;
    sample_done_pin  = 1'b0;
    inputs_ready_pin = 1'b0;
  end

  // True in the two clocks of a pulse starting at a nonzero time.
  function automatic logic hit(input int at, input int t);
    return (at > 0) && (t >= at) && (t < at + 2);
  endfunction : hit

  // One cycle from a SYNC0 pulse; a zero time leaves that event out, which
  // is how the bench commands a missing sample, ready or sync event.
  task automatic run_cycle(input int s1_t, input int smp_t,
                           input int rdy_t, input bit sm);
    for (int t = 0; t < 40; t++) begin
      @(posedge clk_sys);
      #1;
      sync0_pin        = (t < 2);
      sync1_pin        = hit(s1_t, t);
      sample_done_pin  = hit(smp_t, t);
      inputs_ready_pin = hit(rdy_t, t);
      sm_event_pin     = sm && hit(30, t);
    end
  endtask : run_cycle
endmodule : isp_event_src

`default_nettype wire

// ==== dv/test_isp_input_sync.sv ====
// Purpose: Self-checking bench for the input sync parameter object.
// Assumes: Answers come one cycle after each strobe, times are 40 ns/clock.
// Notes:   Drivers queue expectations; a monitor retires them in order.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("BAD %s exp %h got %h", nm, e, g); \
  end \
end

module test_isp_input_sync;
  logic        clk_sys, rst_n, reg_wr_en, reg_rd_en, op_state_pin;
  logic [7:0]  reg_subidx;
  logic [31:0] reg_wdata, reg_rdata, cyc;
  logic        reg_rd_valid, reg_err, sample_req, sync_fault;
  logic        sync0_pin, sync1_pin, sm_event_pin;
  logic        sample_done_pin, inputs_ready_pin;
  logic [33:0] exp_q[$];
  logic [33:0] got, want;
  int          fails, total_checks, n_req, seed;
  logic [7:0]  subs [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                            8'h06, 8'h07, 8'h08, 8'h09, 8'h0b, 8'h0c,
                            8'h0d, 8'h20};
  logic [31:0] rstv [14] = '{32'h20, 32'h22, 32'hf4240, 32'h0, 32'h2,
                            32'h186a0, 32'h0, 32'h0, 32'h0, 32'h0,
                            32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] modes [5] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h22};

  isp_input_sync DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_subidx(reg_subidx), .reg_wdata(reg_wdata),
    .sync0_pin(sync0_pin), .sync1_pin(sync1_pin),
    .sm_event_pin(sm_event_pin), .sample_done_pin(sample_done_pin),
    .inputs_ready_pin(inputs_ready_pin), .op_state_pin(op_state_pin),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_err(reg_err),
    .sample_req(sample_req), .sync_fault(sync_fault));

  isp_event_src src (
    .clk_sys(clk_sys), .sync0_pin(sync0_pin), .sync1_pin(sync1_pin),
    .sm_event_pin(sm_event_pin), .sample_done_pin(sample_done_pin),
    .inputs_ready_pin(inputs_ready_pin));

  // 25 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Each answer on the register port retires the oldest expectation.
  always @(posedge clk_sys) begin
    if (reg_rd_valid === 1'b1 || reg_err === 1'b1) begin
      got = {reg_rd_valid, reg_err, reg_rdata};
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0;
      `CHK("reg answer", want, got)
    end
    if (sample_req === 1'b1) n_req++;
  end

  // The watchdog ends a hung run the same way a finished run ends.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    stop_test();
  end

  // One write; a refused write expects only an error pulse.
  task automatic wr(input logic [7:0] sub, input logic [31:0] d,
                    input logic bad);
    @(posedge clk_sys);
    #1;
    reg_wr_en = 1'b1;
    reg_subidx = sub;
    reg_wdata = d;
    if (bad) exp_q.push_back({1'b0, 1'b1, 32'h0});
    @(posedge clk_sys);
    #1;
    reg_wr_en = 1'b0;
  endtask : wr

  // One read; an unmapped entry answers zero with the error flag.
  task automatic rd(input logic [7:0] sub, input logic [31:0] e,
                    input logic bad);
    @(posedge clk_sys);
    #1;
    reg_rd_en = 1'b1;
    reg_subidx = sub;
    exp_q.push_back({1'b1, bad, e});
    @(posedge clk_sys);
    #1;
    reg_rd_en = 1'b0;
  endtask : rd

  task automatic tdone(input string nm);
    repeat (3) @(posedge clk_sys);
    $display("test %s done", nm);
  endtask : tdone

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // Main sequence: reset table, access kinds, free run, then DC cycles.
  initial begin
    seed = 32'hbf43;
    {rst_n, reg_wr_en, reg_rd_en, op_state_pin} = 4'h0;
    reg_subidx = 8'h00;
    reg_wdata = 32'h0;
    repeat (6) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    `CHK("fault at reset", 1'b0, sync_fault)
    for (int i = 0; i < 14; i++) rd(subs[i], rstv[i], 1'b0);
    rd(8'h0a, 32'h0, 1'b1);
    tdone("reset");
    wr(8'h04, $random(seed), 1'b1);
    rd(8'h04, 32'h2, 1'b0);
    rd(8'h00, 32'h20, 1'b0);
    wr(8'h0e, 32'h1, 1'b1);
    wr(8'h01, 32'h5, 1'b1);
    wr(8'h08, 32'h2, 1'b1);
    foreach (modes[i]) begin
      wr(8'h01, modes[i], 1'b0);
      rd(8'h01, modes[i], 1'b0);
    end
    cyc = $random(seed);
    wr(8'h02, cyc, 1'b0);
    rd(8'h02, cyc, 1'b0);
    tdone("access");
    // A 400 ns cycle ticks every 10 clocks; the window phase allows one off.
    wr(8'h02, 32'd400, 1'b0);
    wr(8'h01, 32'h0, 1'b0);
    n_req = 0;
    repeat (200) @(posedge clk_sys);
    `CHK("free run ticks", 1'b1, (n_req >= 19 && n_req <= 21))
    tdone("free run");
    wr(8'h01, 32'h2, 1'b0);
    op_state_pin = 1'b1;
    wr(8'h08, 32'h1, 1'b0);
    n_req = 0;
    src.run_cycle(3, 10, 16, 1'b1);
    src.run_cycle(3, 6, 9, 1'b0);
    src.run_cycle(3, 8, 0, 1'b1);
    src.run_cycle(3, 8, 12, 1'b1);
    `CHK("dc triggers", 4, n_req)
    rd(8'h03, 32'h190, 1'b0);
    rd(8'h06, 32'hf0, 1'b0);
    rd(8'h09, 32'h118, 1'b0);
    rd(8'h0b, 32'h1, 1'b0);
    rd(8'h0c, 32'h1, 1'b0);
    rd(8'h0d, 32'h4, 1'b0);
    rd(8'h20, 32'h1, 1'b0);
    `CHK("fault pin", 1'b1, sync_fault)
    wr(8'h01, 32'h0, 1'b0);
    repeat (2) @(posedge clk_sys);
    `CHK("fault outside dc", 1'b0, sync_fault)
    tdone("dc maxima");
    wr(8'h08, 32'h0, 1'b0);
    wr(8'h01, 32'h2, 1'b0);
    src.run_cycle(2, 4, 8, 1'b1);
    rd(8'h03, 32'ha0, 1'b0);
    rd(8'h09, 32'h50, 1'b0);
    wr(8'h08, 32'h1, 1'b0);
    rd(8'h03, 32'h0, 1'b0);
    tdone("measure command");
    // The SYNC1 and sync manager triggers each give one request per cycle.
    wr(8'h01, 32'h3, 1'b0);
    n_req = 0;
    src.run_cycle(3, 8, 12, 1'b0);
    `CHK("sync1 triggers", 1, n_req)
    wr(8'h01, 32'h1, 1'b0);
    n_req = 0;
    src.run_cycle(3, 8, 12, 1'b1);
    `CHK("sm triggers", 1, n_req)
    tdone("trigger modes");
    `CHK("queue drained", 0, exp_q.size())
    stop_test();
  end
endmodule : test_isp_input_sync

`default_nettype wire
